// ### shared/scpi_parser_defines.svh
// Purpose: Constants for the remote-command interpreter.
// Assumes: Byte-wide ASCII input stream.
// Notes:   Characters, limits, defaults and status bit positions.
`ifndef SCPI_PARSER_DEFINES_SVH
`define SCPI_PARSER_DEFINES_SVH
`define CH_COLON     8'h3A
`define CH_SEMI      8'h3B
`define CH_COMMA     8'h2C
`define CH_QUERY     8'h3F
`define CH_STAR      8'h2A
`define CH_DQUOTE    8'h22
`define CH_SQUOTE    8'h27
`define CH_HASH      8'h23
`define CH_NL        8'h0A
`define CH_WS_LO_MAX 8'h09
`define CH_WS_HI_MIN 8'h0B
`define CH_WS_HI_MAX 8'h20
`define CH_DIG0      8'h30
`define CH_DIG9      8'h39
`define CH_LOWER_A   8'h61
`define CH_LOWER_Z   8'h7A
`define CASE_BIT     8'h20
`define CH_UP_B      8'h42
`define CH_UP_H      8'h48
`define CH_UP_Q      8'h51
`define CH_ONE       8'h31
`define CH_N         8'h4E
`define CH_A         8'h41
`define MAX_HDR_LEN  6'h20
`define MAX_LEVELS   3'h4
`define DEFAULT_SUFFIX 4'h1
`define NAN_TEXT     64'h392E393145333700
`define ESR_OPC_BIT  0
`define SRE_ESB_BIT  5
`endif

// ### shared/scpi_parser_pkg.sv
// Purpose: Types for the remote-command interpreter.
// Assumes: Used with scpi_parser_defines.svh.
// Notes:   None.
package scpi_parser_pkg;
	typedef enum logic [1:0] {
		fmt_decimal_type,
		fmt_binary_type,
		fmt_octal_type,
		fmt_hex_type
	} num_format_type;
	typedef enum logic [2:0] {
		act_none_type,
		act_setting_type,
		act_query_type,
		act_common_type,
		act_common_query_type
	} action_kind_type;
endpackage

// ### hdl/path_stack.sv
`timescale 1ns/100ps
// Purpose: Small memory holding the hashed header path, one word per level.
// Assumes: One write or clear per cycle.
// Notes:   Read data registered.
module path_stack #(
	parameter int LEVELS = 4,
	parameter int WIDTH  = 16
) (
	// Clock
	input  wire logic                      mclk,
	input  wire logic                      rst,
	input  wire logic                      ce,
	// Access
	input  wire logic                      wr_en,
	input  wire logic [$clog2(LEVELS)-1:0] wr_idx,
	input  wire logic [WIDTH-1:0]          wr_data,
	input  wire logic [$clog2(LEVELS)-1:0] rd_idx,
	output logic      [WIDTH-1:0]          rd_data
);
	logic [WIDTH-1:0] mem_q [LEVELS];

	genvar g;
	generate
		for (g = 0; g < LEVELS; g++) begin : g_lvl
			always_ff @(posedge mclk) begin
				if (rst)
					mem_q[g] <= '0;
				else if (ce && wr_en && wr_idx == g)
					mem_q[g] <= wr_data;
			end
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (rst)
			rd_data <= '0;
		else if (ce)
			rd_data <= mem_q[rd_idx];
	end
endmodule

// ### hdl/scpi_command_parser.sv
`timescale 1ns/100ps
// Purpose: Byte-stream interpreter for remote text command lines.
// Assumes: Lexical tables are hashed; command matching via cmd_* lookup port.
// Notes:   Instrument functions are outside; responses are streamed out.
`include "scpi_parser_defines.svh"

module scpi_command_parser
	import scpi_parser_pkg::*;
#(
	parameter int HASH_W = 16,
	parameter int LEVELS = 4
) (
	// Clock and reset
	input  wire logic                          mclk,
	input  wire logic                          rst,
	input  wire logic                          ce,
	// Input stream
	input  wire logic                          in_valid,
	input  wire logic [7:0]                    in_data,
	input  wire logic                          in_end,
	output logic                               in_ready,
	// Command table lookup (external, combinational)
	output logic      [HASH_W-1:0]             cmd_key,
	input  wire logic                          cmd_known,
	input  wire logic                          cmd_overlapped,
	input  wire logic [HASH_W-1:0]             cmd_id,
	// Action output
	output logic                               act_valid,
	output scpi_parser_pkg::action_kind_type   act_kind,
	output logic      [HASH_W-1:0]             act_id,
	output logic      [3:0]                    act_suffix,
	output scpi_parser_pkg::num_format_type    act_format,
	output logic                               param_valid,
	output logic      [7:0]                    param_data,
	output logic                               param_sep,
	output logic                               param_block,
	output logic                               cmd_rejected,
	// Overlapped operation tracking
	input  wire logic                          op_busy,
	// Status and answers
	output logic                               esr_opc_q,
	input  wire logic                          esr_opc_clear,
	output logic                               resp_valid,
	output logic      [7:0]                    resp_data
);
	typedef enum logic [3:0] {
		st_start, st_header, st_ws, st_param, st_string, st_hash,
		st_blk_len, st_blk_data, st_wait, st_skip
	} state_type;

	state_type         st_q;
	logic [HASH_W-1:0] hash_q;
	logic [HASH_W-1:0] path_hash;
	logic [$clog2(LEVELS)-1:0] lvl_q;
	logic [3:0]        suffix_q;
	logic              query_q;
	logic              common_q;
	logic [7:0]        quote_q;
	logic [3:0]        blk_digits_q;
	logic [31:0]       blk_len_q;
	logic              after_semi_q;
	logic              opc_pend_q;
	logic              answer_q;
	logic [7:0]        ch;
	logic              is_ws;
	logic              is_digit;
	logic              is_term;
	logic              take;
	logic              enter_wait;
	logic              wait_query_q;

	// Case folding makes mnemonic matching blind to letter case
	always_comb begin
		ch = in_data;
		if (in_data >= `CH_LOWER_A && in_data <= `CH_LOWER_Z)
			ch = in_data ^ `CASE_BIT;
	end
	assign is_ws    = (in_data <= `CH_WS_LO_MAX) ||
	                  (in_data >= `CH_WS_HI_MIN && in_data <= `CH_WS_HI_MAX);
	assign is_digit = in_data >= `CH_DIG0 && in_data <= `CH_DIG9;
	assign is_term  = in_data == `CH_NL || in_end;
	assign take     = ce && in_valid && in_ready;
	// Table codes: all ones is operation complete, all ones but bit 0 is wait to continue
	assign enter_wait = take && st_q == st_header && (is_term || is_ws || ch == `CH_SEMI) &&
	                    cmd_known && common_q &&
	                    (query_q ? cmd_id == '1 : cmd_id == {{(HASH_W-1){1'b1}}, 1'b0});

	// Stall input while a synchronising command waits for idle
	always_ff @(posedge mclk) begin
		if (rst)
			in_ready <= 1'b0;
		else if (ce)
			in_ready <= enter_wait ? 1'b0 : (st_q != st_wait || !op_busy);
	end

	path_stack #(.LEVELS(LEVELS), .WIDTH(HASH_W)) u_path (
		.mclk    (mclk),
		.rst     (rst),
		.ce      (ce),
		.wr_en   (take && st_q == st_header && ch == `CH_COLON),
		.wr_idx  (lvl_q),
		.wr_data (hash_q),
		.rd_idx  (lvl_q),
		.rd_data (path_hash)
	);

	// Parse state; the key seen by the table is the rolling header hash
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q         <= st_start;
			hash_q       <= '0;
			lvl_q        <= '0;
			suffix_q     <= `DEFAULT_SUFFIX;
			query_q      <= 1'b0;
			common_q     <= 1'b0;
			quote_q      <= '0;
			blk_digits_q <= '0;
			blk_len_q    <= '0;
			after_semi_q <= 1'b0;
		end else if (take) begin
			unique case (st_q)
				st_start, st_header: begin
					if (st_q == st_start && ch == `CH_COLON) begin
						lvl_q <= '0;
						hash_q <= '0;
					end else if (st_q == st_start && ch == `CH_STAR) begin
						common_q <= 1'b1;
						hash_q <= '1;
					end
					else if (ch == `CH_COLON) begin
						lvl_q <= lvl_q + 1'b1;
						hash_q <= hash_q ^ path_hash;
					end else if (ch == `CH_QUERY)
						query_q <= 1'b1;
					else if (is_digit)
						suffix_q <= in_data[3:0];
					else if (is_term || ch == `CH_SEMI || is_ws)
						st_q <= is_term ? st_start : (is_ws && st_q == st_header ? st_param : st_start);
					else begin
						st_q <= st_header;
						// Rotate-xor hash; alternative spellings map via table
						hash_q <= {hash_q[HASH_W-2:0], hash_q[HASH_W-1]} ^ {{(HASH_W-8){1'b0}}, ch};
					end
					if (is_term) begin
						lvl_q <= '0;
						hash_q <= '0;
						after_semi_q <= 1'b0;
					end else if (ch == `CH_SEMI)
						after_semi_q <= 1'b1;
					if (is_term || ch == `CH_SEMI || is_ws) begin
						query_q  <= query_q && !is_ws ? 1'b0 : query_q;
						// Suffix and common flag must not leak into the next header
						common_q <= 1'b0;
						suffix_q <= `DEFAULT_SUFFIX;
					end
				end
				st_param: begin
					if (ch == `CH_DQUOTE || ch == `CH_SQUOTE) begin
						quote_q <= in_data;
						st_q <= st_string;
					end else if (ch == `CH_HASH)
						st_q <= st_hash;
					else if (is_term || ch == `CH_SEMI) begin
						st_q <= st_start;
						after_semi_q <= !is_term;
						query_q <= 1'b0;
						if (is_term) begin
							lvl_q <= '0;
							hash_q <= '0;
						end
					end
				end
				st_string:
					if (in_data == quote_q)
						st_q <= st_param;
				st_hash:
					if (is_digit && in_data != `CH_DIG0) begin
						blk_digits_q <= in_data[3:0];
						blk_len_q <= '0;
						st_q <= st_blk_len;
					end else
						st_q <= st_param;
				st_blk_len: begin
					blk_len_q <= blk_len_q * 32'd10 + {28'h0, in_data[3:0]};
					blk_digits_q <= blk_digits_q - 1'b1;
					if (blk_digits_q == 4'h1)
						st_q <= st_blk_data;
				end
				st_blk_data: begin
					blk_len_q <= blk_len_q - 1'b1;
					if (blk_len_q <= 32'd1)
						st_q <= st_param;
				end
				st_wait, st_skip:
					if (is_term)
						st_q <= st_start;
			endcase
			if (enter_wait)
				st_q <= st_wait;
		end else if (ce && st_q == st_wait && !op_busy)
			st_q <= st_start;
	end

	// Common headers seed the hash with all ones, so the key is a plain flop
	assign cmd_key = hash_q;

	// Command dispatch at end of header
	always_ff @(posedge mclk) begin
		if (rst) begin
			act_valid    <= 1'b0;
			act_kind     <= act_none_type;
			act_id       <= '0;
			act_suffix   <= `DEFAULT_SUFFIX;
			cmd_rejected <= 1'b0;
		end else if (ce) begin
			act_valid    <= 1'b0;
			cmd_rejected <= 1'b0;
			if (take && (st_q == st_header) && (is_term || is_ws || ch == `CH_SEMI)) begin
				if (!cmd_known)
					cmd_rejected <= 1'b1;
				else begin
					act_valid  <= 1'b1;
					act_id     <= cmd_id;
					act_suffix <= suffix_q;
					act_kind   <= common_q ? (query_q ? act_common_query_type : act_common_type)
					                       : (query_q ? act_query_type : act_setting_type);
				end
			end
		end
	end

	// Parameter byte stream; block payload is raw, terminators untouched
	always_ff @(posedge mclk) begin
		if (rst) begin
			param_valid <= 1'b0;
			param_data  <= '0;
			param_sep   <= 1'b0;
			param_block <= 1'b0;
			act_format  <= fmt_decimal_type;
		end else if (ce) begin
			param_valid <= take && (st_q == st_param || st_q == st_string ||
			               st_q == st_blk_data) &&
			               !(st_q == st_param && (is_ws || is_term || ch == `CH_SEMI));
			param_data  <= in_data;
			param_sep   <= take && st_q == st_param && ch == `CH_COMMA;
			param_block <= take && st_q == st_blk_data;
			if (take && st_q == st_hash) begin
				unique case (ch)
					`CH_UP_B: act_format <= fmt_binary_type;
					`CH_UP_H: act_format <= fmt_hex_type;
					`CH_UP_Q: act_format <= fmt_octal_type;
					default:  act_format <= fmt_decimal_type;
				endcase
			end
		end
	end

	// Synchronisation: operation complete and wait to continue
	always_ff @(posedge mclk) begin
		if (rst) begin
			opc_pend_q <= 1'b0;
			esr_opc_q  <= 1'b0;
			answer_q   <= 1'b0;
			wait_query_q <= 1'b0;
		end else if (ce) begin
			if (enter_wait)
				wait_query_q <= query_q;
			else if (st_q == st_wait && !op_busy)
				wait_query_q <= 1'b0;
			if (act_valid && act_kind == act_common_type && act_id == '1)
				opc_pend_q <= 1'b1;
			else if (opc_pend_q && !op_busy)
				opc_pend_q <= 1'b0;
			// Set wins over clear so a finishing op is not lost
			if (opc_pend_q && !op_busy)
				esr_opc_q <= 1'b1;
			else if (esr_opc_clear)
				esr_opc_q <= 1'b0;
			answer_q <= st_q == st_wait && !op_busy && wait_query_q;
		end
	end

	// Answer: value only, no header echoed
	always_ff @(posedge mclk) begin
		if (rst) begin
			resp_valid <= 1'b0;
			resp_data  <= '0;
		end else if (ce) begin
			resp_valid <= answer_q;
			resp_data  <= `CH_ONE;
		end
	end
	// Numeric, short-form and NaN answers are formatted by the instrument side
endmodule

// ### tb/remote_host.sv
`timescale 1ns/100ps
// Purpose: Remote controller model sending text lines byte by byte
// Assumes: A byte is taken on a rising edge with in_ready high
// Notes:   A tilde in a line stands for the chosen white-space code
module remote_host (
	// Clock and flow
	input  wire logic       mclk,
	input  wire logic       in_ready,
	// Stream
	output logic            in_valid,
	output logic [7:0]      in_data,
	output logic            in_end,
	output int              n_stuck
);
	initial begin
		in_valid = 1'b0;
		in_data = 8'hA5;
		in_end = 1'b0;
		n_stuck = 0;
	end
	task automatic send_line(input string s, input logic eoi, input logic [7:0] ws);
		int k;
		logic rdy;
		for (int i = 0; i < s.len(); i++) begin
			in_valid = 1'b1;
			in_data = (s[i] == "~") ? ws : s[i];
			in_end = eoi && (i == s.len() - 1);
			k = 0;
			// Ready is read at the falling edge, where it is settled
			do begin
				@(negedge mclk);
				rdy = in_ready;
				@(posedge mclk);
				k++;
			end while (rdy !== 1'b1 && k < 200);
			if (k >= 200)
				n_stuck++;
			#1;
		end
		// Released data shows the inverse, never a stale byte
		in_valid = 1'b0;
		in_end = 1'b0;
		in_data = ~in_data;
	endtask
endmodule

// ### tb/scpi_parser_props.sv
`timescale 1ns/100ps
// Purpose: Port checks for the command interpreter
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound after the module
module scpi_parser_props (
	// Clock
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       ce,
	// Observed
	input wire logic       in_valid,
	input wire logic       in_ready,
	input wire logic       act_valid,
	input wire logic [3:0] act_suffix,
	input wire logic       param_valid,
	input wire logic       cmd_rejected,
	input wire logic       op_busy,
	input wire logic       esr_opc_q,
	input wire logic       esr_opc_clear,
	input wire logic       resp_valid,
	input wire logic [7:0] resp_data
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_flag_rise;
		!esr_opc_q ##1 esr_opc_q;
	endsequence
	a_act_from_byte: assert property (act_valid |-> $past(in_valid && in_ready && ce))
		else $error("action without a taken byte");
	a_param_from_byte: assert property (param_valid |-> $past(in_valid && in_ready))
		else $error("parameter without a taken byte");
	a_reject_no_act: assert property (cmd_rejected |-> !act_valid)
		else $error("rejected header also acted");
	a_answer_is_one: assert property (resp_valid |-> resp_data == 8'h31)
		else $error("answer is not one");
	a_answer_when_idle: assert property (resp_valid |-> !$past(op_busy))
		else $error("answer while operations pending");
	a_flag_when_idle: assert property (s_flag_rise |-> !$past(op_busy))
		else $error("complete flag set while busy");
	a_flag_holds: assert property (esr_opc_q && !esr_opc_clear |=> esr_opc_q)
		else $error("complete flag lost without clear");
	a_reset_suffix: assert property (disable iff (1'b0) rst |=> act_suffix == 4'h1)
		else $error("suffix not one after reset");
	a_ready_resumes: assert property (ce && !in_ready && !op_busy |=> in_ready)
		else $error("input held off while idle");
endmodule
bind scpi_command_parser scpi_parser_props u_props (.mclk, .rst, .ce, .in_valid, .in_ready,
	.act_valid, .act_suffix, .param_valid, .cmd_rejected, .op_busy, .esr_opc_q,
	.esr_opc_clear, .resp_valid, .resp_data);

// ### tb/scpi_command_parser_bench.sv
`timescale 1ns/100ps
// Purpose: Self-checking bench for the command interpreter
// Assumes: Lookup table modelled by bench-set id and known flag
// Notes:   Driver queues expectations; a monitor pops them
module scpi_command_parser_bench;
	import scpi_parser_pkg::*;
	logic            mclk = 1'b0, rst = 1'b1, op_busy = 1'b0, esr_opc_clear = 1'b0;
	logic            cmd_known = 1'b1, cmd_overlapped = 1'b0;
	logic [15:0]     cmd_id = 16'h0000;
	logic            in_valid, in_end, in_ready, act_valid, param_valid, param_sep;
	logic            param_block, cmd_rejected, esr_opc_q, resp_valid;
	logic [7:0]      in_data, param_data, resp_data, d, p;
	logic [15:0]     cmd_key, act_id;
	logic [3:0]      act_suffix;
	action_kind_type act_kind;
	num_format_type  act_format;
	int              n_mismatch = 0, n_checks = 0, n_stuck, n_rej = 0, n_rsp = 0;
	int              seed = 32'hD114;
	logic [22:0]     exp_act[$];
	logic [7:0]      exp_par[$];
	logic [7:0]      ws_set[4] = '{8'h00, 8'h09, 8'h0B, 8'h20};
	string           line;
	always #12.5 mclk = ~mclk;
	scpi_command_parser dut (.mclk, .rst, .ce(1'b1), .in_valid, .in_data, .in_end, .in_ready,
		.cmd_key, .cmd_known, .cmd_overlapped, .cmd_id, .act_valid, .act_kind, .act_id,
		.act_suffix, .act_format, .param_valid, .param_data, .param_sep, .param_block,
		.cmd_rejected, .op_busy, .esr_opc_q, .esr_opc_clear, .resp_valid, .resp_data);
	remote_host host (.mclk, .in_ready, .in_valid, .in_data, .in_end, .n_stuck);
	task automatic check(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	task automatic stop_test();
		n_mismatch += n_stuck + exp_act.size() + exp_par.size() + n_rej + n_rsp;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Zero actions means the table calls the header unknown
	task automatic cmd(input string s, input action_kind_type k, input logic [3:0] sfx,
			input int n, input logic eoi, input logic [7:0] ws);
		cmd_known = (n != 0);
		n_rej += (n == 0);
		cmd_id = (k < act_common_type) ? 16'($random(seed)) : (s == "*WAI\n") ? 16'hFFFE : 16'hFFFF;
		for (int i = 0; i < n; i++)
			exp_act.push_back({k, cmd_id, sfx});
		host.send_line(s, eoi, ws);
		repeat (3) @(posedge mclk);
		#1;
	endtask
	// Sender runs apart, as the line may stall while busy
	task automatic sync(input string s, input action_kind_type k);
		int w;
		op_busy = 1'b1;
		n_rsp = (k == act_common_query_type);
		fork
			cmd(s, k, 4'h1, 1, 0, 8'h20);
		join_none
		repeat (12) @(posedge mclk);
		#1;
		check(esr_opc_q === 1'b0 && n_rsp == int'(k == act_common_query_type) &&
			in_ready === (s == "*OPC\n"), "early");
		op_busy = 1'b0;
		for (w = 0; w < 40 && (exp_act.size() > 0 || n_rsp > 0 || in_ready !== 1'b1 ||
				(s == "*OPC\n" && esr_opc_q !== 1'b1)); w++) begin
			@(posedge mclk);
			#1;
		end
		wait fork;
		check(w < 40, "no completion");
		if (w == 40)
			stop_test();
		if (s == "*OPC\n")
			check(esr_opc_q === 1'b1, "complete flag");
		esr_opc_clear = 1'b1;
		@(posedge mclk);
		#1;
		esr_opc_clear = 1'b0;
		check(esr_opc_q === 1'b0, "flag clear");
	endtask
	always @(negedge mclk) begin
		if (act_valid === 1'b1)
			check(exp_act.size() > 0 && {act_kind, act_id, act_suffix} === exp_act.pop_front(), "action");
		if (param_valid === 1'b1 && param_sep !== 1'b1)
			check(exp_par.size() > 0 && param_data === exp_par.pop_front(), "param");
		if (resp_valid === 1'b1) begin
			check(n_rsp > 0 && resp_data === 8'h31, "answer");
			n_rsp = (n_rsp > 0) ? n_rsp - 1 : 0;
		end
		if (cmd_rejected === 1'b1) begin
			check(n_rej > 0, "rejection");
			n_rej = (n_rej > 0) ? n_rej - 1 : 0;
		end
	end
	initial begin
		#2000000;
		check(1'b0, "watchdog");
		stop_test();
	end
	initial begin
		repeat (4) @(posedge mclk);
		#1;
		rst = 1'b0;
		check(act_suffix === 4'h1 && esr_opc_q === 1'b0, "reset values");
		@(posedge mclk);
		#1;
		check(in_ready === 1'b1, "ready");
		$display("test reset done");
		cmd("AB\n", act_setting_type, 4'h1, 1, 0, 8'h20);
		cmd("AB?\n", act_query_type, 4'h1, 1, 0, 8'h20);
		cmd("AB3\n", act_setting_type, 4'h3, 1, 0, 8'h20);
		cmd("AB;CD\n", act_setting_type, 4'h1, 2, 0, 8'h20);
		cmd(":AB;:CD\n", act_setting_type, 4'h1, 2, 0, 8'h20);
		cmd("AB", act_setting_type, 4'h1, 1, 1, 8'h20);
		cmd("AB\n", act_setting_type, 4'h1, 1, 1, 8'h20);
		cmd("ZZ\n", act_none_type, 4'h1, 0, 0, 8'h20);
		$display("test headers done");
		foreach (ws_set[i]) begin
			exp_par.push_back(8'h35);
			exp_par.push_back(8'h36);
			cmd("AB~5,6\n", act_setting_type, 4'h1, 1, 0, ws_set[i]);
		end
		repeat (20) begin
			d = 8'h31 + 8'($random(seed) & 7);
			p = 8'h30 + 8'($random(seed) & 7);
			line = "AB0~0\n";
			line[2] = d;
			line[4] = p;
			exp_par.push_back(p);
			cmd(line, act_setting_type, d[3:0], 1, 0, ws_set[$random(seed) & 3]);
		end
		$display("test parameters done");
		sync("*OPC\n", act_common_type);
		sync("*OPC?\n", act_common_query_type);
		sync("*WAI\n", act_common_type);
		$display("test sync done");
		stop_test();
	end
endmodule
